// ===== core/lpw_pkg.sv
// Shared constants for the low-power mode and wakeup controller.
// Assumes a single always-on clock hclk that keeps running in every mode;
// gating of the CPU, memory and system clocks is done outside from the enables.

package lpw_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the AHB-Lite slave
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00; // Peripheral mode programming
  localparam logic [7:0] OFS_EDGE   = 8'h04; // Edge port configuration
  localparam logic [7:0] OFS_FLAG   = 8'h08; // Edge flags, write one to clear
  localparam logic [7:0] OFS_STATUS = 8'h0C; // Controller state, read only

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int CTL_WDOG_WAIT = 0;  // Watchdog freezes in wait
  localparam int CTL_WDOG_DOZE = 1;  // Watchdog freezes in doze
  localparam int CTL_PIT_DOZE  = 2;  // Two bits, periodic timers freeze in doze
  localparam int CTL_SCI_DOZE  = 4;  // Two bits, async ports freeze in doze
  localparam int CTL_SPI_DOZE  = 6;  // Serial port gates its clocks in doze
  localparam int CTL_SPE       = 7;  // Serial port enable
  localparam int CTL_CONV_HALT = 8;  // Converter halt
  localparam int CTL_TIM_RUN   = 9;  // Timer run
  localparam int CTL_PACC_EN   = 10; // Pulse accumulator enable
  localparam int CTL_W         = 11; // Implemented control width
  localparam logic [10:0] CTL_RST = 11'h000;

  // ----------------------------------------------------------------
  // Edge register field positions (one byte per field)
  // ----------------------------------------------------------------
  localparam int EDG_EN   = 0;  // Pin interrupt enable
  localparam int EDG_MODE = 8;  // 1 edge detect, 0 low-level detect
  localparam int EDG_RISE = 16; // Edge polarity: 1 rising, 0 falling
  localparam logic [23:0] EDG_RST = 24'h00_0000;

  // ----------------------------------------------------------------
  // Timing counts in hclk cycles
  // ----------------------------------------------------------------
  localparam logic [4:0] FLASH_WAKE_CYC = 5'h10; // Flash clocks before system clocks
  localparam logic [2:0] RST_QUAL_CYC   = 3'h4;  // Reset pin low time to qualify

  // ----------------------------------------------------------------
  // Low-power mode codes from the instruction decoder
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_RUN  = 2'h0;
  localparam logic [1:0] MODE_WAIT = 2'h1;
  localparam logic [1:0] MODE_DOZE = 2'h2;
  localparam logic [1:0] MODE_STOP = 2'h3;

  // ----------------------------------------------------------------
  // Controller states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RUN   = 5'b0_0001, // Normal operation
    ST_ENTER = 5'b0_0010, // Entry in progress
    ST_LOWP  = 5'b0_0100, // Resting in the selected mode
    ST_FWAKE = 5'b0_1000, // Flash-only clocking after stop
    ST_DEBUG = 5'b1_0000  // Debug session interrupting a mode
  } lpw_state_t;

endpackage : lpw_pkg

// ===== core/lpw_ctrl.sv
// Low-power mode sequencer, wakeup logic and peripheral mode controls.
// Assumes hclk is always-on; gated clocks are built outside from the
// registered enables with latch-based gates; interrupt sources are levels.
//
// Contract
// - Test-access logic never causes a wakeup
// - Interrupt path to processor purely combinational; pin edges here go via synchronisers and flags
// - Fast request wakes only with allow bit
// - Normal request wakes with both enable bits
// - Wait/doze: pins wake on edge or level
// - Stop: edge detect off, level only
// - RAM off in low power, instant return
// - Flash low power when idle, no delay
// - Converter runs, may wake in wait/doze
// - Stop or halt bit freezes converter, aborts
// - Converter resumes; software waits before converting
// - Watchdog freezes in stop, programmable wait/doze
// - Unfrozen watchdog reset ends low power
// - Periodic timers freeze in stop, programmable doze
// - Serial port: wait runs, doze programmable
// - Serial port off in stop or disabled
// - Async ports freeze in stop, programmable doze
// - Run/accumulator bits disable timer functions
// - Capture timers freeze only in stop
// - Debug request ends mode, mode re-entered after
// - Interrupt wake goes straight to service
// - Modes applied at instruction; core/memories stopped
// - Instruction idles core, stop holds clock low
// - Wait/doze gate core/memory clocks only
// - Stop wake: sixteen flash clocks first
// - Reset pin qualified over four clocks
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.

`timescale 1ns/1ps

module lpw_ctrl #(
  parameter int NPIN = 8,  // External interrupt pins
  parameter int NFST = 4,  // Fast interrupt sources
  parameter int NNRM = 16  // Normal interrupt sources
) (
  // Clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // AHB-Lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  // Processor side
  input  wire logic            lp_req,
  input  wire logic [1:0]      lp_mode,
  input  wire logic            fast_irq_allow_bit,
  input  wire logic            irq_enable_bit,
  input  wire logic            exception_enable_bit,
  input  wire logic            flash_access,
  output logic                 cpu_fast_irq,
  output logic                 cpu_norm_irq,
  output logic                 irq_service,
  output logic                 chip_reset_req,
  // Interrupt and wakeup sources
  input  wire logic [NFST-1:0] fast_irq_src,
  input  wire logic [NNRM-1:0] norm_irq_src,
  input  wire logic [NPIN-1:0] ext_irq_pin,
  input  wire logic            debug_req,
  input  wire logic            halt_request_pin_n,
  input  wire logic            reset_pin_n,
  input  wire logic            wdog_timeout,
  // Clock enables
  output logic                 cpu_clk_en,
  output logic                 ram_en,
  output logic                 flash_clk_en,
  output logic                 flash_low_power,
  output logic                 sys_clk_en,
  // Peripheral mode controls
  output logic                 wdog_freeze,
  output logic [1:0]           pit_freeze,
  output logic [1:0]           sci_freeze,
  output logic                 spi_enable,
  output logic                 spi_clkgen_off,
  output logic                 conv_freeze,
  output logic                 conv_abort,
  output logic                 tim_freeze,
  output logic                 tim_run,
  output logic                 pacc_run
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  localparam int SW = NPIN + 3; // Pins plus debug, halt, reset pin
  localparam logic [SW-1:0] SYNC_RST = {2'b11, 1'b0, {NPIN{1'b1}}}; // Idle levels

  typedef struct packed {
    lpw_pkg::lpw_state_t st;        // Sequencer state
    logic [1:0]          mode;      // Latched low-power mode
    logic [4:0]          cnt;       // Flash wake counter
    logic                pend;      // Wake seen during entry
    logic                by_irq;    // Wake cause was an interrupt
    logic [2:0]          rcnt;      // Reset pin low counter
    logic [SW-1:0]       s1;        // Synchroniser stage 1
    logic [SW-1:0]       s2;        // Synchroniser stage 2
    logic [SW-1:0]       s3;        // Synchroniser stage 3
    logic [SW-1:0]       filt;      // Agreed input levels
    logic [NPIN-1:0]     eflag;     // Sticky edge flags
    logic [lpw_pkg::CTL_W-1:0] ctl; // Control register
    logic [23:0]         edg;       // Edge configuration
    logic                dsel;      // Write pending in data phase
    logic [7:0]          dadr;      // Address of pending write
    logic [31:0]         rdat;      // Read data for data phase
    logic                cfz_d;     // Converter freeze, delayed
    logic                svc;       // Service pulse
    logic                rst_o;     // Qualified reset pulse
    logic                cpu_en;    // Core clock enable
    logic                flash_en;  // Flash clock enable
    logic                sys_en;    // System clock enable
  } lpw_reg_t;

  lpw_reg_t r_r;   // Current state
  lpw_reg_t r_nxt; // Next state

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Effective mode seen by peripherals for a given state and mode
  function automatic logic [1:0] eff_mode(input lpw_pkg::lpw_state_t st,
                                          input logic [1:0] mode);
    eff_mode = (st == lpw_pkg::ST_ENTER || st == lpw_pkg::ST_LOWP ||
                st == lpw_pkg::ST_FWAKE) ? mode : lpw_pkg::MODE_RUN;
  endfunction : eff_mode

  // ----------------------------------------------------------------
  // Combinational wake paths
  // ----------------------------------------------------------------
  logic [1:0]      mode_e;    // Current effective mode
  logic            in_stop;   // Stop mode active
  logic            in_wait;   // Wait mode active
  logic            in_doze;   // Doze mode active
  logic [NPIN-1:0] lvl_irq;   // Low-level pin requests
  logic            pin_irq;   // Edge port request
  logic            wake_irq;  // Interrupt that may wake
  logic            dbg_any;   // Debug entry requested
  logic            wdog_rst;  // Watchdog reset allowed
  logic            rst_stop;  // Reset pin during stop

  assign mode_e  = eff_mode(r_r.st, r_r.mode);
  assign in_stop = (mode_e == lpw_pkg::MODE_STOP);
  assign in_wait = (mode_e == lpw_pkg::MODE_WAIT);
  assign in_doze = (mode_e == lpw_pkg::MODE_DOZE);

  // Level detect uses the raw pin; no clock exists for it in stop
  assign lvl_irq = r_r.edg[lpw_pkg::EDG_EN +: NPIN] & ~r_r.edg[lpw_pkg::EDG_MODE +: NPIN]
                   & ~ext_irq_pin;
  assign pin_irq = |(lvl_irq | (r_r.eflag & r_r.edg[lpw_pkg::EDG_EN +: NPIN]));

  // No flop between the fast and normal sources or the level pins and the request lines; edge flags are registered
  assign cpu_fast_irq = |fast_irq_src;
  assign cpu_norm_irq = (|norm_irq_src) | pin_irq;

  assign wake_irq = (cpu_fast_irq & fast_irq_allow_bit)
                  | (cpu_norm_irq & irq_enable_bit & exception_enable_bit);

  // Debug port request and halt pin only; test-access logic has no input here
  assign dbg_any  = r_r.filt[NPIN] | ~r_r.filt[NPIN+1];
  assign wdog_rst = wdog_timeout & ~wdog_freeze;

  // In stop the pin is not synchronised: it resets asynchronously
  assign rst_stop = in_stop & ~reset_pin_n;
  assign chip_reset_req = r_r.rst_o | wdog_rst | rst_stop;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic            wake;    // Any wake condition
    logic            wr_hit;  // Data-phase write
    logic            rd_go;   // Address-phase read
    logic [NPIN-1:0] pin_now; // Filtered pins, this cycle
    logic [NPIN-1:0] pin_old; // Filtered pins, previous
    logic [NPIN-1:0] edge_ev; // Configured edges seen
    logic [NPIN-1:0] clr;     // Flags cleared by software
    logic [1:0]      mode_n;  // Mode for next cycle
    logic            stop_n;  // Stop in next cycle
    r_nxt   = r_r;
    wake    = wake_irq | dbg_any;
    wr_hit  = r_r.dsel;
    rd_go   = hsel & hready & htrans[1] & ~hwrite;
    clr     = '0;
    {pin_old, pin_now, edge_ev, mode_n, stop_n} = '0;

    // Three-stage synchronisers; a change counts when stages 2 and 3 agree
    r_nxt.s1 = {reset_pin_n, halt_request_pin_n, debug_req, ext_irq_pin};
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    for (int i = 0; i < SW; i++)
    begin
      if (r_r.s2[i] == r_r.s3[i])
        r_nxt.filt[i] = r_r.s3[i];
    end

    // Edge detection is clockless in stop, so it is disabled there
    pin_old = r_r.filt[NPIN-1:0];
    pin_now = r_nxt.filt[NPIN-1:0];
    edge_ev = r_r.edg[lpw_pkg::EDG_MODE +: NPIN]
            & ((r_r.edg[lpw_pkg::EDG_RISE +: NPIN] & ~pin_old & pin_now)
            | (~r_r.edg[lpw_pkg::EDG_RISE +: NPIN] & pin_old & ~pin_now));
    if (in_stop)
      edge_ev = '0;

    // Reset pin qualification; applies in run, wait and doze
    r_nxt.rst_o = 1'b0;
    if (r_r.filt[NPIN+2])
      r_nxt.rcnt = '0;
    else if (r_r.rcnt != lpw_pkg::RST_QUAL_CYC)
    begin
      r_nxt.rcnt = r_r.rcnt + 3'h1;
      r_nxt.rst_o = (r_r.rcnt == lpw_pkg::RST_QUAL_CYC - 3'h1);
    end

    // Register write in data phase
    if (wr_hit)
    begin
      unique case (r_r.dadr)
        lpw_pkg::OFS_CTRL: r_nxt.ctl = hwdata[lpw_pkg::CTL_W-1:0];
        lpw_pkg::OFS_EDGE: r_nxt.edg = hwdata[23:0];
        lpw_pkg::OFS_FLAG: clr = hwdata[NPIN-1:0];
        default: ;
      endcase
    end
    // A new edge wins over a clear in the same cycle
    r_nxt.eflag = (r_r.eflag & ~clr) | edge_ev;

    // Address phase capture; reads answer from a flop next cycle
    r_nxt.dsel = hsel & hready & htrans[1] & hwrite;
    if (hsel & hready & htrans[1])
      r_nxt.dadr = {haddr[7:2], 2'b00};
    if (rd_go)
    begin
      unique case ({haddr[7:2], 2'b00})
        lpw_pkg::OFS_CTRL:   r_nxt.rdat = 32'(r_r.ctl);
        lpw_pkg::OFS_EDGE:   r_nxt.rdat = {8'h00, r_r.edg};
        lpw_pkg::OFS_FLAG:   r_nxt.rdat = 32'(r_r.eflag);
        lpw_pkg::OFS_STATUS: r_nxt.rdat = {16'h0000, 8'(r_r.filt[NPIN-1:0]),
                                           r_r.pend, r_r.mode, r_r.st};
        default:             r_nxt.rdat = 32'h0000_0000;
      endcase
    end

    // Sequencer
    r_nxt.svc = 1'b0;
    unique case (r_r.st)
      lpw_pkg::ST_RUN:
      begin
        // Mode is applied as the instruction executes
        if (lp_req && lp_mode != lpw_pkg::MODE_RUN)
        begin
          r_nxt.st   = lpw_pkg::ST_ENTER;
          r_nxt.mode = lp_mode;
          r_nxt.pend = 1'b0;
        end
      end
      lpw_pkg::ST_ENTER:
      begin
        // Entry is not abandoned; a wake here is kept for later
        r_nxt.pend   = wake;
        r_nxt.by_irq = wake_irq & ~dbg_any;
        r_nxt.st     = lpw_pkg::ST_LOWP;
      end
      lpw_pkg::ST_LOWP:
      begin
        if (wake | r_r.pend)
        begin
          r_nxt.pend = 1'b0;
          if (!r_r.pend)
            r_nxt.by_irq = wake_irq & ~dbg_any;
          if (dbg_any)
            r_nxt.st = lpw_pkg::ST_DEBUG;
          else if (r_r.mode == lpw_pkg::MODE_STOP)
          begin
            r_nxt.st  = lpw_pkg::ST_FWAKE;
            r_nxt.cnt = '0;
          end
          else
          begin
            r_nxt.st  = lpw_pkg::ST_RUN;
            r_nxt.svc = r_r.pend ? r_r.by_irq : wake_irq;
          end
        end
      end
      lpw_pkg::ST_FWAKE:
      begin
        // Flash is clocked alone until its recovery count is done
        r_nxt.cnt = r_r.cnt + 5'h01;
        if (r_r.cnt == lpw_pkg::FLASH_WAKE_CYC - 5'h01)
        begin
          r_nxt.st  = lpw_pkg::ST_RUN;
          r_nxt.svc = r_r.by_irq;
        end
      end
      lpw_pkg::ST_DEBUG:
      begin
        // Leaving debug returns to the interrupted mode, settings kept
        if (!dbg_any)
          r_nxt.st = lpw_pkg::ST_ENTER;
      end
    endcase

    // Any reset source ends the mode
    if (chip_reset_req)
    begin
      r_nxt.st   = lpw_pkg::ST_RUN;
      r_nxt.pend = 1'b0;
    end

    // Clock enables follow the next state, so they only change at an edge
    mode_n = eff_mode(r_nxt.st, r_nxt.mode);
    stop_n = (mode_n == lpw_pkg::MODE_STOP);
    r_nxt.cpu_en   = (mode_n == lpw_pkg::MODE_RUN);
    r_nxt.flash_en = r_nxt.cpu_en | (r_nxt.st == lpw_pkg::ST_FWAKE);
    r_nxt.sys_en   = ~stop_n;
    r_nxt.cfz_d    = conv_freeze;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r_r          <= '0;
      r_r.st       <= lpw_pkg::ST_RUN;
      r_r.s1       <= SYNC_RST;
      r_r.s2       <= SYNC_RST;
      r_r.s3       <= SYNC_RST;
      r_r.filt     <= SYNC_RST;
      r_r.ctl      <= lpw_pkg::CTL_RST;
      r_r.edg      <= lpw_pkg::EDG_RST;
      r_r.cpu_en   <= 1'b1;
      r_r.flash_en <= 1'b1;
      r_r.sys_en   <= 1'b1;
    end
    else
      r_r <= r_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = r_r.rdat;

  assign irq_service  = r_r.svc;
  assign cpu_clk_en   = r_r.cpu_en;
  assign ram_en       = r_r.cpu_en;
  assign flash_clk_en = r_r.flash_en;
  // Flash rests whenever not addressed, so wake needs no extra delay
  assign flash_low_power = ~(r_r.flash_en & flash_access);
  assign sys_clk_en   = r_r.sys_en;

  // Peripheral freezes are levels; released freezes resume from held state
  assign wdog_freeze = in_stop
                     | (in_wait & r_r.ctl[lpw_pkg::CTL_WDOG_WAIT])
                     | (in_doze & r_r.ctl[lpw_pkg::CTL_WDOG_DOZE]);

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_dual
      assign pit_freeze[g] = in_stop | (in_doze & r_r.ctl[lpw_pkg::CTL_PIT_DOZE + g]);
      assign sci_freeze[g] = in_stop | (in_doze & r_r.ctl[lpw_pkg::CTL_SCI_DOZE + g]);
    end
  endgenerate

  // Gated clock generation stops master shifts; slave bytes use the
  // external clock and still finish
  assign spi_enable     = r_r.ctl[lpw_pkg::CTL_SPE] & ~in_stop;
  assign spi_clkgen_off = ~spi_enable
                        | (in_doze & r_r.ctl[lpw_pkg::CTL_SPI_DOZE]);

  // Converter runs through wait and doze; it has no settle timer here
  assign conv_freeze = in_stop | r_r.ctl[lpw_pkg::CTL_CONV_HALT];
  assign conv_abort  = conv_freeze & ~r_r.cfz_d;

  // Capture timers ignore wait and doze; a reset clears them anyway
  assign tim_freeze = in_stop;
  assign tim_run    = r_r.ctl[lpw_pkg::CTL_TIM_RUN];
  assign pacc_run   = r_r.ctl[lpw_pkg::CTL_PACC_EN];

endmodule : lpw_ctrl

// ===== test/lpw_properties.sv
// Port checker for the low-power controller: entry, clocks, freezes, resets.
// Assumes it is bound into lpw_ctrl, with one clock hclk and reset hresetn.
`timescale 1ns/1ps
module lpw_properties (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Processor side and reset sources
  input wire logic       lp_req,
  input wire logic [1:0] lp_mode,
  input wire logic       flash_access,
  input wire logic       wdog_timeout,
  input wire logic       chip_reset_req,
  // Clock enables and freezes
  input wire logic       cpu_clk_en,
  input wire logic       ram_en,
  input wire logic       flash_clk_en,
  input wire logic       flash_low_power,
  input wire logic       sys_clk_en,
  input wire logic       wdog_freeze,
  input wire logic [1:0] pit_freeze,
  input wire logic [1:0] sci_freeze,
  input wire logic       tim_freeze,
  input wire logic       conv_freeze,
  input wire logic       spi_enable
);
  // -------------------
  // Properties
  // -------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Instruction taken in run; a reset request would override it
  wire go = lp_req && cpu_clk_en && !chip_reset_req;
  a_enter_gates_core: assert property (go && lp_mode != 2'h0 |=> !cpu_clk_en)
    else $error("core clock still on after entry");
  a_stop_clock_low: assert property (go && lp_mode == 2'h3 |=> !sys_clk_en && !flash_clk_en)
    else $error("system clock running in stop");
  a_wait_keeps_sys: assert property (go && lp_mode inside {2'h1, 2'h2} |=>
    sys_clk_en && !flash_clk_en) else $error("wrong clocks in wait or doze");
  a_ram_with_core: assert property (ram_en == cpu_clk_en)
    else $error("ram enable differs from core clock");
  a_flash_idle_low: assert property (flash_low_power == !(flash_clk_en && flash_access))
    else $error("flash low-power state wrong");
  a_stop_freezes_all: assert property (!sys_clk_en && !flash_clk_en |->
    wdog_freeze && conv_freeze && tim_freeze && pit_freeze == 2'b11 && sci_freeze == 2'b11
    && !spi_enable) else $error("peripheral running in stop");
  a_timer_runs_awake: assert property (sys_clk_en |-> !tim_freeze)
    else $error("timer frozen outside stop");
  a_flash_first_wake: assert property ($rose(flash_clk_en) && !sys_clk_en |->
    (!sys_clk_en) [*8] ##1 (!sys_clk_en) [*8] ##1 sys_clk_en)
    else $error("flash-only wake span wrong");
  a_wdog_reset_live: assert property (wdog_timeout && !wdog_freeze |-> chip_reset_req)
    else $error("watchdog timeout gave no reset");
  c_stop: cover property (go && lp_mode == 2'h3);
  c_flash_wake: cover property ($rose(flash_clk_en) && !sys_clk_en);
  c_wake: cover property ($rose(cpu_clk_en));
  c_reset: cover property (chip_reset_req);
endmodule : lpw_properties

// ===== test/lpw_core_model.sv
// Core model: executes the low-power instruction when the bench asks.
// Assumes the bench requests one instruction at a time.
`timescale 1ns/1ps
module lpw_core_model (
  // Clock, reset and bench request
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       exec_go,
  input  wire logic [1:0] exec_mode,
  input  wire logic       cpu_clk_en,
  // Instruction strobe and mode
  output logic            lp_req,
  output logic [1:0]      lp_mode
);
  // A gated core executes nothing; mode toggles while exec_go is low
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      lp_req  <= 1'b0;
      lp_mode <= 2'h0;
    end
    else
    begin
      lp_req  <= exec_go & cpu_clk_en;
      lp_mode <= exec_go ? exec_mode : ~lp_mode;
    end
endmodule : lpw_core_model

// ===== test/lpw_ctrl_bench.sv
// Bench for lpw_ctrl: AHB master, core model, wake and freeze scenarios.
// Assumes a single slave, so hready is the controller's own hreadyout.
`timescale 1ns/1ps
module lpw_ctrl_bench;
  // -------------------
  // Signals, inputs valued at time zero
  // -------------------
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, exec_go = 1'b0;
  logic        fast_irq_allow_bit = 1'b0, irq_enable_bit = 1'b0, exception_enable_bit = 1'b0;
  logic        flash_access = 1'b0, debug_req = 1'b0, wdog_timeout = 1'b0, hit;
  logic        halt_request_pin_n = 1'b1, reset_pin_n = 1'b1, hready, hreadyout, hresp;
  logic        lp_req, cpu_fast_irq, cpu_norm_irq, irq_service, chip_reset_req, cpu_clk_en;
  logic        ram_en, flash_clk_en, flash_low_power, sys_clk_en, wdog_freeze, spi_enable;
  logic        spi_clkgen_off, conv_freeze, conv_abort, tim_freeze, tim_run, pacc_run;
  logic [1:0]  htrans = 2'h0, exec_mode = 2'h0, lp_mode, pit_freeze, sci_freeze;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  fast_irq_src = 4'h0;
  logic [7:0]  ext_irq_pin = 8'hFF;
  logic [15:0] norm_irq_src = 16'h0000;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [31:0] seed = 32'h54ba_a1ee;
  int          num_errors = 0, check_count = 0, cnt;
  assign hready = hreadyout;
  lpw_ctrl u_dut (.*);
  lpw_core_model u_core (.*);
  initial
  begin
    forever #10 hclk = ~hclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Fast request needs its allow bit, normal needs both enables
  function automatic logic wakes(input logic f, a, i, e);
    return f ? a : (i & e);
  endfunction : wakes
  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Single word transfer; waits on hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wait_cpu(input logic v);
    for (int i = 0; i < 12 && cpu_clk_en !== v; i++) @(posedge hclk);
  endtask : wait_cpu
  task automatic sleep(input logic [1:0] m);
    exec_mode <= m;
    exec_go   <= 1'b1;
    @(posedge hclk);
    exec_go   <= 1'b0;
    wait_cpu(1'b0);
  endtask : sleep
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  // Hang guard
  initial
  begin
    repeat (5000) @(posedge hclk);
    num_errors++;
    conclude();
  end
  // -------------------
  // Scenarios
  // -------------------
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, lpw_pkg::OFS_CTRL, 32'h0000_0000);
    check("ctrl_rst", rd, {21'h0, lpw_pkg::CTL_RST});
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      flash_access <= seed[12];
      ahb(1'b1, lpw_pkg::OFS_CTRL, seed);
      ahb(1'b0, lpw_pkg::OFS_CTRL, 32'h0000_0000);
      check("ctrl", rd, seed & 32'h0000_07FF);
      check("tim_run", tim_run, seed[9]);
      check("pacc_run", pacc_run, seed[10]);
      check("conv_freeze", conv_freeze, seed[8]);
      check("spi_enable", spi_enable, seed[7]);
    end
    ahb(1'b1, lpw_pkg::OFS_CTRL, 32'h0000_0000);
    for (int k = 0; k < 16; k++)
    begin
      {fast_irq_allow_bit, irq_enable_bit, exception_enable_bit} <= k[2:0];
      sleep(lpw_pkg::MODE_WAIT);
      fast_irq_src <= {3'h0, k[3]};
      norm_irq_src <= {!k[3], 15'h0000};
      wait_cpu(1'b1);
      check("wake", cpu_clk_en, wakes(k[3], k[2], k[1], k[0]));
      @(posedge hclk);
      fast_irq_allow_bit <= 1'b1;
      fast_irq_src       <= 4'h1;
      wait_cpu(1'b1);
      @(posedge hclk);
      fast_irq_src       <= 4'h0;
      norm_irq_src       <= 16'h0000;
    end
    ahb(1'b1, lpw_pkg::OFS_CTRL, 32'h0000_0001);
    sleep(lpw_pkg::MODE_WAIT);
    check("wdog_freeze", wdog_freeze, 1'b1);
    wdog_timeout <= 1'b1;
    repeat (2) @(posedge hclk);
    check("frozen_reset", chip_reset_req, 1'b0);
    ahb(1'b1, lpw_pkg::OFS_CTRL, 32'h0000_00FC);
    wait_cpu(1'b1);
    check("wdog_wake", cpu_clk_en, 1'b1);
    wdog_timeout <= 1'b0;
    sleep(lpw_pkg::MODE_DOZE);
    check("pit_freeze", pit_freeze, 2'b11);
    check("sci_freeze", sci_freeze, 2'b11);
    check("tim_freeze", tim_freeze, 1'b0);
    check("spi_clkgen_off", spi_clkgen_off, 1'b1);
    debug_req <= 1'b1;
    wait_cpu(1'b1);
    check("debug_exit", cpu_clk_en, 1'b1);
    debug_req <= 1'b0;
    wait_cpu(1'b0);
    check("reenter", cpu_clk_en, 1'b0);
    reset_pin_n <= 1'b0;
    repeat (2) @(posedge hclk);
    reset_pin_n <= 1'b1;
    repeat (6) @(posedge hclk);
    check("short_pin", cpu_clk_en, 1'b0);
    hit = 1'b0;
    reset_pin_n <= 1'b0;
    repeat (10)
    begin
      @(posedge hclk);
      hit = hit | (chip_reset_req === 1'b1);
    end
    check("pin_reset", {hit, cpu_clk_en}, 2'b11);
    reset_pin_n <= 1'b1;
    ahb(1'b1, lpw_pkg::OFS_EDGE, 32'h0000_0001);
    sleep(lpw_pkg::MODE_STOP);
    check("sys_clk_en", sys_clk_en, 1'b0);
    check("conv_abort", conv_abort, 1'b1);
    ext_irq_pin <= 8'hFE;
    #2 check("level_irq", cpu_norm_irq, 1'b1);
    cnt = 0;
    hit = 1'b0;
    repeat (30)
    begin
      @(posedge hclk);
      cnt = cnt + int'(flash_clk_en === 1'b1 && sys_clk_en === 1'b0);
      hit = hit | (irq_service === 1'b1);
    end
    check("flash_span", cnt, 16);
    check("service", {hit, cpu_clk_en}, 2'b11);
    ahb(1'b1, lpw_pkg::OFS_EDGE, 32'h0000_0202);
    sleep(lpw_pkg::MODE_WAIT);
    ext_irq_pin <= 8'hFC;
    wait_cpu(1'b1);
    check("edge_wake", cpu_clk_en, 1'b1);
    conclude();
  end
endmodule : lpw_ctrl_bench
bind lpw_ctrl lpw_properties u_props (.*);
